// file: core/mul_ctl_pkg.sv
package mul_ctl_pkg;
	// ----------------------------------------
	// Opcode prefixes
	// ----------------------------------------
	localparam logic [7:0] OP_LOAD_FACTOR = 8'h6a;
	localparam logic [7:0] OP_LOAD_FACTOR_ADD = 8'h6c;
	localparam logic [7:0] OP_LOAD_FACTOR_ADD_MOVE = 8'h6b;
	localparam logic [7:0] OP_MULTIPLY = 8'h6d;
	localparam logic [7:0] OP_SHIFT_COPY = 8'h69;
	localparam logic [7:0] OP_TABLE_READ = 8'h67;
	localparam logic [7:0] OP_TABLE_WRITE = 8'h7d;
	localparam logic [7:0] OP_STATUS_RESTORE = 8'h7b;
	localparam logic [7:0] OP_STATUS_SAVE = 8'h7c;
	localparam logic [2:0] OP_MUL_IMM = 3'h4;
	localparam logic [4:0] OP_PORT_IN = 5'h08;
	localparam logic [4:0] OP_PORT_OUT = 5'h09;
	localparam logic [15:0] OP_ADD_PRODUCT = 16'h7f8f;
	localparam logic [15:0] OP_PRODUCT_TO_ACC = 16'h7f8e;
	localparam logic [15:0] OP_SUB_PRODUCT = 16'h7f90;
	localparam logic [15:0] OP_IRQ_DISABLE = 16'h7f81;
	localparam logic [15:0] OP_IRQ_ENABLE = 16'h7f82;
	localparam logic [15:0] OP_NO_OP = 16'h7f80;
	localparam logic [15:0] OP_POP = 16'h7f9d;
	localparam logic [15:0] OP_PUSH = 16'h7f9c;
	localparam logic [15:0] OP_SAT_CLEAR = 16'h7f8a;
	localparam logic [15:0] OP_SAT_SET = 16'h7f8b;
	// ----------------------------------------
	// Field positions and sizes
	// ----------------------------------------
	localparam int IND_BIT = 7;
	localparam int STACK_DEPTH = 4;
	localparam logic [1:0] STACK_TOP = 2'h3;
	localparam logic [1:0] CYC_ONE = 2'h0;
	localparam logic [1:0] CYC_TWO = 2'h1;
	localparam logic [1:0] CYC_THREE = 2'h2;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam int ST_IRQ_MASK = 1;
	localparam int ST_SAT = 0;
	localparam int ST_PAGE = 8;
	localparam int ST_ARP = 9;
	localparam logic [31:0] ACC_MAX = 32'h7fffffff;
	localparam logic [31:0] ACC_MIN = 32'h80000000;
endpackage

// file: core/ret_stack.sv
`timescale 1ns/1ps
// Small hardware return stack built from flip-flops
module ret_stack (
	input wire logic clk_in, // Clock
	input wire logic rst_b_in, // Async reset, active low
	input wire logic push_in, // Push strobe
	input wire logic pop_in, // Pop strobe
	input wire logic [15:0] data_in, // Word to push
	output logic [15:0] top_out // Current top word
);
	logic [15:0] slot [mul_ctl_pkg::STACK_DEPTH];

	assign top_out = slot[0];

	// ----------------------------------------
	// Shift register stack; overflow drops the oldest word
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < mul_ctl_pkg::STACK_DEPTH; i++) begin
				slot[i] <= 16'h0000;
			end
		end else if (push_in) begin
			slot[0] <= data_in;
			for (int i = 1; i < mul_ctl_pkg::STACK_DEPTH; i++) begin
				slot[i] <= slot[i-1];
			end
		end else if (pop_in) begin
			for (int i = 0; i < mul_ctl_pkg::STACK_DEPTH - 1; i++) begin
				slot[i] <= slot[i+1];
			end
		end
	end
endmodule

// file: core/mul_ctl_decode.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Add product adds product register into accumulator, one cycle, one word.
// - Load factor add loads factor register and accumulates product, one cycle.
// - Load factor add move also copies data word to next location, one cycle.
// - Multiply: factor times data word into product register, one cycle.
// - Top bits 100: multiply factor by 13-bit immediate into product, one cycle.
// - Product to accumulator loads accumulator from product, one cycle.
// - Subtract product subtracts product register from accumulator, one cycle.
// - Pop moves stack top into accumulator in two cycles.
// - Push puts the low 16 bits of the accumulator onto stack in two cycles.
// - Shift copy copies addressed data word to next location, one cycle.
// - Port in/out move a word between selected port and memory, two cycles.
// - Table read moves a program word into data memory in three cycles.
// - Table write moves a data word into program memory in three cycles.
module mul_ctl_decode (
	input wire logic clk_in, // Machine cycle clock
	input wire logic rst_b_in, // Async reset, active low
	input wire logic [15:0] instr_in, // Instruction word, sampled when ready
	input wire logic [15:0] data_rd_in, // Data memory read word
	input wire logic [15:0] port_rd_in, // Port read word
	input wire logic [15:0] prog_rd_in, // Program memory read word
	input wire logic [7:0] aux_addr_in, // Current auxiliary register value
	output logic instr_ready_out, // High when a new instruction is accepted
	output logic [7:0] data_addr_out, // Data memory address
	output logic data_we_out, // Data memory write strobe
	output logic [15:0] data_wr_out, // Data memory write word
	output logic [2:0] port_sel_out, // Selected port number
	output logic port_rd_out, // Port read strobe
	output logic port_we_out, // Port write strobe
	output logic [15:0] port_wr_out, // Port write word
	output logic [15:0] prog_addr_out, // Program memory address for tables
	output logic prog_rd_out, // Program memory read strobe
	output logic prog_we_out, // Program memory write strobe
	output logic [15:0] prog_wr_out, // Program memory write word
	output logic [31:0] acc_out, // Accumulator
	output logic [31:0] product_out, // Product register
	output logic [15:0] factor_out, // Factor register
	output logic [15:0] status_out, // Status register
	output logic irq_mask_out // Interrupts masked when high
);
	typedef enum logic [2:0] {
		ST_FETCH = 3'b001,
		ST_WAIT = 3'b010,
		ST_LAST = 3'b100
	} phase_e;

	phase_e phase;
	phase_e next_phase;
	logic [15:0] op;
	logic [31:0] acc;
	logic [31:0] product;
	logic [15:0] factor;
	logic [15:0] status;
	logic [15:0] stack_top;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// While fetching, decode the word on the bus; later cycles use the held copy
	wire logic [15:0] cur;
	wire logic [7:0] hi;

	assign cur = (phase == ST_FETCH) ? instr_in : op;
	assign hi = cur[15:8];

	wire logic is_add_prod;
	wire logic is_prod_to_acc;
	wire logic is_sub_prod;
	wire logic is_load_factor;
	wire logic is_load_add;
	wire logic is_load_add_move;
	wire logic is_mult;
	wire logic is_mult_imm;
	wire logic is_shift_copy;
	wire logic is_in;
	wire logic is_out;
	wire logic is_table_rd;
	wire logic is_table_wr;
	wire logic is_pop;
	wire logic is_push;
	wire logic is_status_restore;
	wire logic is_status_save;
	wire logic is_irq_off;
	wire logic is_irq_on;
	wire logic is_sat_clear;
	wire logic is_sat_set;

	// Whole-word opcodes
	assign is_add_prod = cur == mul_ctl_pkg::OP_ADD_PRODUCT;
	assign is_prod_to_acc = cur == mul_ctl_pkg::OP_PRODUCT_TO_ACC;
	assign is_sub_prod = cur == mul_ctl_pkg::OP_SUB_PRODUCT;
	assign is_pop = cur == mul_ctl_pkg::OP_POP;
	assign is_push = cur == mul_ctl_pkg::OP_PUSH;
	assign is_irq_off = cur == mul_ctl_pkg::OP_IRQ_DISABLE;
	assign is_irq_on = cur == mul_ctl_pkg::OP_IRQ_ENABLE;
	assign is_sat_clear = cur == mul_ctl_pkg::OP_SAT_CLEAR;
	assign is_sat_set = cur == mul_ctl_pkg::OP_SAT_SET;

	// Upper-byte opcodes; the low byte carries the data address
	assign is_load_factor = hi == mul_ctl_pkg::OP_LOAD_FACTOR;
	assign is_load_add = hi == mul_ctl_pkg::OP_LOAD_FACTOR_ADD;
	assign is_load_add_move = hi == mul_ctl_pkg::OP_LOAD_FACTOR_ADD_MOVE;
	assign is_mult = hi == mul_ctl_pkg::OP_MULTIPLY;
	assign is_shift_copy = hi == mul_ctl_pkg::OP_SHIFT_COPY;
	assign is_table_rd = hi == mul_ctl_pkg::OP_TABLE_READ;
	assign is_table_wr = hi == mul_ctl_pkg::OP_TABLE_WRITE;
	assign is_status_restore = hi == mul_ctl_pkg::OP_STATUS_RESTORE;
	assign is_status_save = hi == mul_ctl_pkg::OP_STATUS_SAVE;

	// Short prefixes; the word-wide opcodes above all sit outside these ranges
	assign is_mult_imm = cur[15:13] == mul_ctl_pkg::OP_MUL_IMM;
	assign is_in = cur[15:11] == mul_ctl_pkg::OP_PORT_IN;
	assign is_out = cur[15:11] == mul_ctl_pkg::OP_PORT_OUT;

	// ----------------------------------------
	// Cycle count
	// ----------------------------------------
	// Cycles beyond the first that each opcode needs
	wire logic [1:0] extra;
	wire logic last;

	assign extra = (is_table_rd | is_table_wr) ? mul_ctl_pkg::CYC_THREE :
		(is_pop | is_push | is_in | is_out) ? mul_ctl_pkg::CYC_TWO :
		mul_ctl_pkg::CYC_ONE;
	// A one-cycle opcode finishes in its own fetch cycle
	assign last = (phase == ST_FETCH) ? (extra == mul_ctl_pkg::CYC_ONE) : (phase == ST_LAST);

	// ----------------------------------------
	// Addressing
	// ----------------------------------------
	wire logic ind;
	wire logic [7:0] ea;
	wire logic copy_next;

	assign ind = cur[mul_ctl_pkg::IND_BIT];
	assign ea = ind ? aux_addr_in : {status[mul_ctl_pkg::ST_PAGE], cur[6:0]};
	// Copy ops read the source and write the word above it in the same cycle,
	// so the memory must return the source word while the address shows ea + 1
	assign copy_next = last && (is_shift_copy | is_load_add_move);

	// ----------------------------------------
	// Arithmetic
	// ----------------------------------------
	wire logic [31:0] factor_wide;
	wire logic [31:0] data_wide;
	wire logic [31:0] imm_wide;
	wire logic [31:0] mul_data;
	wire logic [31:0] mul_imm;
	wire logic [32:0] acc_add;
	wire logic [32:0] acc_sub;
	wire logic [32:0] acc_sum;
	wire logic sat_on;
	wire logic ovf;
	wire logic [31:0] acc_sat;

	// Operands widened by hand so the low 32 product bits never depend on cast rules
	assign factor_wide = {{16{factor[15]}}, factor};
	assign data_wide = {{16{data_rd_in[15]}}, data_rd_in};
	assign imm_wide = {{19{cur[12]}}, cur[12:0]};
	assign mul_data = factor_wide * data_wide;
	assign mul_imm = factor_wide * imm_wide;

	// One guard bit shows when the 32-bit result has wrapped
	assign acc_add = {acc[31], acc} + {product[31], product};
	assign acc_sub = {acc[31], acc} - {product[31], product};
	assign acc_sum = is_sub_prod ? acc_sub : acc_add;
	// Saturation only bites when the mode bit is set
	assign sat_on = status[mul_ctl_pkg::ST_SAT];
	assign ovf = acc_sum[32] ^ acc_sum[31];
	assign acc_sat = (sat_on && ovf) ?
		(acc_sum[32] ? mul_ctl_pkg::ACC_MIN : mul_ctl_pkg::ACC_MAX) : acc_sum[31:0];

	// ----------------------------------------
	// Strobes: effects fire on the final cycle
	// ----------------------------------------
	wire logic do_acc_sum;
	wire logic do_push;
	wire logic do_pop;

	assign do_acc_sum = last &&
		(is_add_prod | is_load_add | is_load_add_move | is_sub_prod);
	assign do_push = last && is_push;
	assign do_pop = last && is_pop;

	// ----------------------------------------
	// Memory and port side
	// ----------------------------------------
	assign instr_ready_out = (phase == ST_FETCH);
	assign data_addr_out = copy_next ? 8'(ea + 8'h01) : ea;
	assign data_we_out = copy_next ||
		(last && (is_in | is_table_rd | is_status_save));
	assign data_wr_out = is_in ? port_rd_in :
		is_table_rd ? prog_rd_in :
		is_status_save ? status : data_rd_in;
	assign port_sel_out = cur[10:8];
	assign port_rd_out = last && is_in;
	assign port_we_out = last && is_out;
	assign port_wr_out = data_rd_in;
	// Table address comes from the accumulator, so it is set up by earlier code
	assign prog_addr_out = acc[15:0];
	assign prog_rd_out = last && is_table_rd;
	assign prog_we_out = last && is_table_wr;
	assign prog_wr_out = data_rd_in;

	// ----------------------------------------
	// Register views
	// ----------------------------------------
	assign acc_out = acc;
	assign product_out = product;
	assign factor_out = factor;
	assign status_out = status;
	assign irq_mask_out = status[mul_ctl_pkg::ST_IRQ_MASK];

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		next_phase = phase;
		case (phase)
			ST_FETCH: begin
				if (extra == mul_ctl_pkg::CYC_TWO) begin
					next_phase = ST_LAST;
				end else if (extra == mul_ctl_pkg::CYC_THREE) begin
					next_phase = ST_WAIT;
				end
			end
			ST_WAIT: next_phase = ST_LAST;
			ST_LAST: next_phase = ST_FETCH;
			default: next_phase = ST_FETCH;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			phase <= ST_FETCH;
			op <= 16'h0000;
		end else begin
			phase <= next_phase;
			if (phase == ST_FETCH) begin
				op <= instr_in;
			end
		end
	end

	// ----------------------------------------
	// Datapath registers
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			acc <= 32'h00000000;
		end else if (do_acc_sum) begin
			acc <= acc_sat;
		end else if (last && is_prod_to_acc) begin
			acc <= product;
		end else if (do_pop) begin
			acc <= {16'h0000, stack_top};
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			factor <= 16'h0000;
		end else if (last && (is_load_factor | is_load_add | is_load_add_move)) begin
			factor <= data_rd_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			product <= 32'h00000000;
		end else if (last && is_mult) begin
			product <= mul_data;
		end else if (last && is_mult_imm) begin
			product <= mul_imm;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			status <= mul_ctl_pkg::STATUS_RESET;
		end else if (last) begin
			if (is_irq_off) begin
				status[mul_ctl_pkg::ST_IRQ_MASK] <= 1'b1;
			end else if (is_irq_on) begin
				status[mul_ctl_pkg::ST_IRQ_MASK] <= 1'b0;
			end else if (is_sat_clear) begin
				status[mul_ctl_pkg::ST_SAT] <= 1'b0;
			end else if (is_sat_set) begin
				status[mul_ctl_pkg::ST_SAT] <= 1'b1;
			end else if (is_status_restore) begin
				status <= data_rd_in;
			end
		end
	end

	ret_stack u_stack (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.push_in(do_push),
		.pop_in(do_pop),
		.data_in(acc[15:0]),
		.top_out(stack_top)
	);
endmodule

// file: dv/mul_ctl_props.sv
`timescale 1ns/1ps
module mul_ctl_props (
	input wire logic clk_in, rst_b_in, instr_ready_out, data_we_out, port_rd_out,
	input wire logic prog_rd_out, irq_mask_out,
	input wire logic [2:0] port_sel_out,
	input wire logic [7:0] aux_addr_in, data_addr_out,
	input wire logic [15:0] instr_in, data_rd_in, port_rd_in, prog_rd_in, data_wr_out,
	input wire logic [15:0] factor_out, status_out,
	input wire logic [31:0] acc_out, product_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	wire logic go = instr_ready_out;
	wire logic [7:0] hi = instr_in[15:8];
	wire logic [2:0] psel = instr_in[10:8];
	wire logic [7:0] ea = instr_in[7] ? aux_addr_in : {status_out[8], instr_in[6:0]};
	// Sign-extended operands keep the 32-bit product check free of signed casts
	wire logic [31:0] fx = {{16{factor_out[15]}}, factor_out};
	wire logic [31:0] dx = {{16{data_rd_in[15]}}, data_rd_in};
	wire logic [31:0] ix = {{19{instr_in[12]}}, instr_in[12:0]};
	wire logic [31:0] acc_sum = acc_out + product_out;
	property p_add;
		go && instr_in == mul_ctl_pkg::OP_ADD_PRODUCT && !status_out[0] |=> acc_out == $past(acc_sum);
	endproperty
	a_add: assert property (p_add) else $error("product not added");
	property p_load_add;
		go && hi == mul_ctl_pkg::OP_LOAD_FACTOR_ADD && !status_out[0]
		|=> factor_out == $past(data_rd_in) && acc_out == $past(acc_sum);
	endproperty
	a_load_add: assert property (p_load_add) else $error("load and add wrong");
	property p_copy;
		go && (hi == mul_ctl_pkg::OP_SHIFT_COPY || hi == mul_ctl_pkg::OP_LOAD_FACTOR_ADD_MOVE)
		|-> data_we_out && data_addr_out == ea + 8'h01 && data_wr_out == data_rd_in;
	endproperty
	a_copy: assert property (p_copy) else $error("copy to next word wrong");
	property p_multiply;
		go && hi == mul_ctl_pkg::OP_MULTIPLY |-> data_addr_out == ea ##1 product_out == $past(fx) * $past(dx);
	endproperty
	a_multiply: assert property (p_multiply) else $error("multiply wrong");
	property p_mul_imm;
		go && instr_in[15:13] == mul_ctl_pkg::OP_MUL_IMM |=> product_out == $past(fx) * $past(ix);
	endproperty
	a_mul_imm: assert property (p_mul_imm) else $error("immediate multiply wrong");
	property p_to_acc;
		go && instr_in == mul_ctl_pkg::OP_PRODUCT_TO_ACC |=> go && acc_out == $past(product_out);
	endproperty
	a_to_acc: assert property (p_to_acc) else $error("product not moved");
	property p_pop;
		go && instr_in == mul_ctl_pkg::OP_POP |=> !go ##1 go && acc_out[31:16] == 16'h0000;
	endproperty
	a_pop: assert property (p_pop) else $error("pop timing wrong");
	property p_push;
		go && instr_in == mul_ctl_pkg::OP_PUSH |=> !go ##1 go && acc_out == $past(acc_out, 2);
	endproperty
	a_push: assert property (p_push) else $error("push timing wrong");
	property p_port_in;
		go && instr_in[15:11] == mul_ctl_pkg::OP_PORT_IN |=> !go && port_rd_out && data_we_out
		&& port_sel_out == $past(psel) && data_wr_out == port_rd_in ##1 go;
	endproperty
	a_port_in: assert property (p_port_in) else $error("port input wrong");
	property p_table_read;
		go && hi == mul_ctl_pkg::OP_TABLE_READ |=> !go && !prog_rd_out
		##1 !go && prog_rd_out && data_we_out && data_wr_out == prog_rd_in ##1 go;
	endproperty
	a_table_read: assert property (p_table_read) else $error("table read wrong");
	property p_irq_off;
		go && instr_in == mul_ctl_pkg::OP_IRQ_DISABLE |=> go && irq_mask_out && status_out[1];
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("mask not set");
	c_push: cover property (go && instr_in == mul_ctl_pkg::OP_PUSH);
	c_table: cover property (go && hi == mul_ctl_pkg::OP_TABLE_READ);
	c_port: cover property (go && instr_in[15:11] == mul_ctl_pkg::OP_PORT_IN);
endmodule

// file: dv/mem_model.sv
`timescale 1ns/1ps
module mem_model (
	input wire logic clk_in, data_we_in, port_rd_in, port_we_in, prog_rd_in, prog_we_in,
	input wire logic [7:0] data_addr_in,
	input wire logic [2:0] port_sel_in,
	input wire logic [15:0] data_wr_in, port_wr_in, prog_addr_in, prog_wr_in,
	output logic [15:0] data_word_out, port_word_out, prog_word_out
);
	logic [15:0] dmem [256];
	logic [15:0] pmem [64];
	logic [15:0] ports [8];
	logic [15:0] noise = 16'h5a5a;
	// Copy ops present the next address while writing, so the source is one below
	assign data_word_out = data_we_in ? dmem[data_addr_in - 8'h01] : dmem[data_addr_in];
	// Undriven buses show a changing pattern, never the last word
	assign port_word_out = port_rd_in ? ports[port_sel_in] : noise;
	assign prog_word_out = prog_rd_in ? pmem[prog_addr_in[5:0]] : ~noise;
	always @(posedge clk_in) begin
		noise <= {noise[14:0], noise[15] ^ noise[13]};
		if (data_we_in) dmem[data_addr_in] <= data_wr_in;
		if (port_we_in) ports[port_sel_in] <= port_wr_in;
		if (prog_we_in) pmem[prog_addr_in[5:0]] <= prog_wr_in;
	end
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk_in, rst_b_in;
	logic [15:0] instr_in;
	logic [7:0] aux_addr_in;
	wire logic [15:0] data_rd_in, port_rd_in, prog_rd_in, data_wr_out, port_wr_out;
	wire logic [15:0] prog_addr_out, prog_wr_out, factor_out, status_out;
	wire logic [31:0] acc_out, product_out;
	wire logic [7:0] data_addr_out;
	wire logic [2:0] port_sel_out;
	wire logic instr_ready_out, data_we_out, port_rd_out, port_we_out, prog_rd_out;
	wire logic prog_we_out, irq_mask_out;
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [31:0] p;
	mul_ctl_decode uut (.*);
	mem_model mem (.clk_in(clk_in), .data_we_in(data_we_out), .port_rd_in(port_rd_out),
		.port_we_in(port_we_out), .prog_rd_in(prog_rd_out), .prog_we_in(prog_we_out),
		.data_addr_in(data_addr_out), .port_sel_in(port_sel_out), .data_wr_in(data_wr_out),
		.port_wr_in(port_wr_out), .prog_addr_in(prog_addr_out), .prog_wr_in(prog_wr_out),
		.data_word_out(data_rd_in), .port_word_out(port_rd_in), .prog_word_out(prog_rd_in));
	task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Replaces the word with a no-op once taken so it cannot run twice
	task automatic issue(input logic [15:0] op, input int ncyc);
		int n;
		n = 1;
		@(posedge clk_in);
		instr_in <= op;
		@(posedge clk_in);
		instr_in <= mul_ctl_pkg::OP_NO_OP;
		#1;
		while (instr_ready_out !== 1'b1 && n < 8) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		cmp("cycles", 32'(ncyc), 32'(n));
	endtask
	function automatic logic [15:0] dir(input logic [7:0] op, input logic [6:0] a);
		return {op, 1'b0, a};
	endfunction
	task automatic t_multiply;
		mem.dmem[10] = 16'h0123;
		mem.dmem[11] = 16'hfffe;
		mem.dmem[8'h90] = 16'h0005;
		issue(dir(mul_ctl_pkg::OP_LOAD_FACTOR, 7'h0a), 1);
		cmp("factor", 32'h0000_0123, {16'h0000, factor_out});
		issue(dir(mul_ctl_pkg::OP_MULTIPLY, 7'h0b), 1);
		cmp("product", 32'h0000_0123 * 32'hffff_fffe, product_out);
		issue({mul_ctl_pkg::OP_MULTIPLY, 8'h80}, 1);
		cmp("product", 32'h0000_0123 * 32'h0000_0005, product_out);
		issue({mul_ctl_pkg::OP_MUL_IMM, 13'h1ffd}, 1);
		cmp("product", 32'h0000_0123 * 32'hffff_fffd, product_out);
	endtask
	task automatic t_accumulate;
		p = 32'h0000_0123 * 32'h0000_0007;
		issue({mul_ctl_pkg::OP_MUL_IMM, 13'h0007}, 1);
		issue(mul_ctl_pkg::OP_PRODUCT_TO_ACC, 1);
		cmp("acc", p, acc_out);
		issue(mul_ctl_pkg::OP_ADD_PRODUCT, 1);
		cmp("acc", 2 * p, acc_out);
		issue(mul_ctl_pkg::OP_SUB_PRODUCT, 1);
		cmp("acc", p, acc_out);
		mem.dmem[12] = 16'h0040;
		issue(dir(mul_ctl_pkg::OP_LOAD_FACTOR_ADD, 7'h0c), 1);
		cmp("factor", 32'h0000_0040, {16'h0000, factor_out});
		cmp("acc", 2 * p, acc_out);
		mem.dmem[20] = 16'h0033;
		issue(dir(mul_ctl_pkg::OP_LOAD_FACTOR_ADD_MOVE, 7'h14), 1);
		cmp("acc", 3 * p, acc_out);
		cmp("moved", 32'h0000_0033, {16'h0000, mem.dmem[21]});
		mem.dmem[30] = 16'h0777;
		issue(dir(mul_ctl_pkg::OP_SHIFT_COPY, 7'h1e), 1);
		cmp("copied", 32'h0000_0777, {16'h0000, mem.dmem[31]});
	endtask
	task automatic t_stack;
		issue(mul_ctl_pkg::OP_PUSH, 2);
		issue(mul_ctl_pkg::OP_PRODUCT_TO_ACC, 1);
		issue(mul_ctl_pkg::OP_PUSH, 2);
		issue({mul_ctl_pkg::OP_MUL_IMM, 13'h0001}, 1);
		issue(mul_ctl_pkg::OP_PRODUCT_TO_ACC, 1);
		issue(mul_ctl_pkg::OP_POP, 2);
		cmp("pop", {16'h0000, p[15:0]}, acc_out);
		issue(mul_ctl_pkg::OP_POP, 2);
		p = 3 * p;
		cmp("pop", {16'h0000, p[15:0]}, acc_out);
	endtask
	task automatic t_ports_tables;
		mem.dmem[40] = 16'hbeef;
		mem.ports[5] = 16'h1357;
		issue({mul_ctl_pkg::OP_PORT_OUT, 3'h3, 1'b0, 7'h28}, 2);
		cmp("port", 32'h0000_beef, {16'h0000, mem.ports[3]});
		issue({mul_ctl_pkg::OP_PORT_IN, 3'h5, 1'b0, 7'h29}, 2);
		cmp("port in", 32'h0000_1357, {16'h0000, mem.dmem[41]});
		issue(dir(mul_ctl_pkg::OP_TABLE_WRITE, 7'h28), 3);
		cmp("table", 32'h0000_beef, {16'h0000, mem.pmem[p[5:0]]});
		issue(dir(mul_ctl_pkg::OP_TABLE_READ, 7'h2a), 3);
		cmp("table rd", 32'h0000_beef, {16'h0000, mem.dmem[42]});
	endtask
	task automatic t_control;
		issue(mul_ctl_pkg::OP_IRQ_DISABLE, 1);
		cmp("mask", 32'h1, {31'h0, irq_mask_out});
		issue(mul_ctl_pkg::OP_IRQ_ENABLE, 1);
		cmp("mask", 32'h0, {31'h0, irq_mask_out});
		issue(mul_ctl_pkg::OP_SAT_SET, 1);
		issue(dir(mul_ctl_pkg::OP_STATUS_SAVE, 7'h32), 1);
		cmp("saved", 32'h0000_0001, {16'h0000, mem.dmem[50]});
		issue(mul_ctl_pkg::OP_SAT_CLEAR, 1);
		cmp("status", 32'h0, {16'h0000, status_out});
		issue(dir(mul_ctl_pkg::OP_STATUS_RESTORE, 7'h32), 1);
		cmp("status", 32'h0000_0001, {16'h0000, status_out});
		// Overflow clamps while saturation is on and wraps once it is off
		mem.dmem[60] = 16'h8000;
		issue(dir(mul_ctl_pkg::OP_LOAD_FACTOR, 7'h3c), 1);
		issue(dir(mul_ctl_pkg::OP_MULTIPLY, 7'h3c), 1);
		cmp("product", 32'h4000_0000, product_out);
		issue(mul_ctl_pkg::OP_PRODUCT_TO_ACC, 1);
		issue(mul_ctl_pkg::OP_ADD_PRODUCT, 1);
		cmp("acc", mul_ctl_pkg::ACC_MAX, acc_out);
		issue(mul_ctl_pkg::OP_SAT_CLEAR, 1);
		issue(mul_ctl_pkg::OP_ADD_PRODUCT, 1);
		cmp("acc", 32'hbfff_ffff, acc_out);
	endtask
	task automatic tally_and_finish;
		if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			tally_and_finish();
		end
	end
	initial begin
		rst_b_in = 1'b0;
		instr_in = mul_ctl_pkg::OP_NO_OP;
		aux_addr_in = 8'h90;
		repeat (10) @(posedge clk_in);
		rst_b_in <= 1'b1;
		t_multiply();
		t_accumulate();
		t_stack();
		t_ports_tables();
		t_control();
		tally_and_finish();
	end
endmodule
bind mul_ctl_decode mul_ctl_props chk (.*);
